//--- design/apdu_consts.svh
// constants of the select/read command decoder
// assumes inclusion by the decoder and the bench only
`ifndef APDU_CONSTS_SVH
`define APDU_CONSTS_SVH
`define CLA_OK 8'h00
`define INS_SELECT 8'hA4
`define INS_READ 8'hB0
`define P1_FILE_ID 8'h00
`define P1_EF 8'h02
`define P1_NAME 8'h04
`define P2_DESIGNATE 8'h00
`define P2_NO_FCI 8'h0C
`define PAIR_EF {`P1_EF, `P2_NO_FCI}
`define PAIR_APP {`P1_NAME, `P2_DESIGNATE}
`define PAIR_FILE {`P1_FILE_ID, `P2_NO_FCI}
`define LC_APP 8'h07
`define LC_FILE 8'h02
`define AID_NDEF 56'hD2760000850101
`define FID_CC 16'hE103
`define FID_NDEF 16'h0103
`define LE_APP 8'h00
`define LE_MIN 8'h01
`define LE_MAX 8'hFB
`define LEN_READ 5'h05
`define LEN_SEL_FILE 5'h07
`define LEN_SEL_APP 5'h0D
`define LEN_SAT 5'h11
`define FRAME_MAX 16
`define SW_OK 16'h9000
`define SW_BAD_CLA 16'h6E00
`define SW_BAD_INS 16'h6D00
`define SW_BAD_P1P2 16'h6A86
`define SW_BAD_LEN 16'h6700
`define SW_BAD_DATA 16'h6A82
`endif

//--- design/apdu_pkg.sv
// types of the select/read command decoder
// assumes apdu_consts.svh on the include path
package apdu_pkg;
  typedef enum logic [6:0] {
    S_RX   = 7'h01,
    S_CHK  = 7'h02,
    S_MRD  = 7'h04,
    S_MWT  = 7'h08,
    S_DATA = 7'h10,
    S_SW1  = 7'h20,
    S_SW2  = 7'h40
  } state_type;
  typedef enum logic [2:0] {
    SEL_NONE = 3'h0,
    SEL_EF   = 3'h1,
    SEL_APP  = 3'h2,
    SEL_CC   = 3'h3,
    SEL_NDEF = 3'h4
  } sel_type;
endpackage

//--- design/byte_stream_if.sv
// valid/ready byte stream carrier between the decoder and its buffer
// assumes one clock shared by both ends
`timescale 1ns/1ps
interface byte_stream_if #(parameter int WIDTH = 9);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

//--- design/resp_buffer.sv
// two-entry buffer in the response byte path
// assumes the sink may hold ready low for any number of cycles
`timescale 1ns/1ps
module resp_buffer (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  byte_stream_if.snk in_if,
  byte_stream_if.src out_if
);
  logic [$bits(in_if.data)-1:0] head_r, head_nxt, tail_r, tail_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic push, pop;
  logic vld_r, vld_nxt;

  assign in_if.ready = (cnt_r != 2'h2);
  assign out_if.valid = vld_r;
  assign out_if.data = head_r;
  assign push = in_if.valid && in_if.ready;
  assign pop = out_if.valid && out_if.ready;

  always_comb begin
    head_nxt = head_r;
    tail_nxt = tail_r;
    cnt_nxt = cnt_r;
    unique case (cnt_r)
      2'h0: if (push) begin
        head_nxt = in_if.data;
        cnt_nxt = 2'h1;
      end
      2'h1: if (push && pop) begin
        head_nxt = in_if.data;
      end else if (push) begin
        tail_nxt = in_if.data;
        cnt_nxt = 2'h2;
      end else if (pop) begin
        cnt_nxt = 2'h0;
      end
      2'h2: if (pop) begin
        head_nxt = tail_r;
        cnt_nxt = 2'h1;
      end
      default: cnt_nxt = 2'h0;
    endcase
    vld_nxt = (cnt_nxt != 2'h0);
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      head_r <= '0;
      tail_r <= '0;
      cnt_r <= 2'h0;
      vld_r <= 1'b0;
    end else begin
      head_r <= head_nxt;
      tail_r <= tail_nxt;
      cnt_r <= cnt_nxt;
      vld_r <= vld_nxt;
    end
  end
endmodule // resp_buffer

//--- design/apdu_select_read_decoder.sv
// select/read command decoder with response stream and memory read port
// assumes command bytes and memory data come from logic on i_clk_sys;
// memory returns i_mem_rdata one cycle after o_mem_rd is high
`timescale 1ns/1ps
`include "apdu_consts.svh"
module apdu_select_read_decoder (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  input wire logic i_rx_last,
  output logic o_rx_ready,
  output logic o_tx_valid,
  output logic [7:0] o_tx_data,
  output logic o_tx_last,
  input wire logic i_tx_ready,
  output logic o_mem_rd,
  output logic [15:0] o_mem_addr,
  input wire logic [7:0] i_mem_rdata,
  output apdu_pkg::sel_type o_sel_target,
  output logic [15:0] o_sel_fid
);
  import apdu_pkg::*;

  state_type state_r, state_nxt;
  sel_type sel_r, sel_nxt, chk_tgt;
  logic [7:0] frm_r [0:`FRAME_MAX-1];
  logic [7:0] frm_nxt [0:`FRAME_MAX-1];
  logic [4:0] cnt_r, cnt_nxt;
  logic [15:0] sw_r, sw_nxt, chk_sw;
  logic [15:0] addr_r, addr_nxt, fid_r, fid_nxt, pair_w, id_w;
  logic [7:0] left_r, left_nxt, data_r, data_nxt;
  logic rx_rdy_r, rx_rdy_nxt, rd_r, rd_nxt, chk_rd;
  logic take;

  byte_stream_if #(.WIDTH(9)) push_if ();
  byte_stream_if #(.WIDTH(9)) tx_if ();

  assign take = i_rx_valid && rx_rdy_r;
  assign pair_w = {frm_r[2], frm_r[3]};
  assign id_w = {frm_r[5], frm_r[6]};

  // field checks, header bytes in arrival order, then frame length and Le ahead of the data bytes
  always_comb begin
    chk_sw = `SW_OK;
    chk_tgt = sel_r;
    chk_rd = 1'b0;
    if (frm_r[0] != `CLA_OK) begin
      chk_sw = `SW_BAD_CLA;
    end else if (cnt_r < 5'h2) begin
      chk_sw = `SW_BAD_LEN;
    end else if (frm_r[1] == `INS_SELECT) begin
      if (cnt_r < 5'h4) begin
        chk_sw = `SW_BAD_LEN;
      end else if (pair_w != `PAIR_EF && pair_w != `PAIR_APP &&
                   pair_w != `PAIR_FILE) begin
        chk_sw = `SW_BAD_P1P2;
      end else if (cnt_r < 5'h5 || frm_r[4] !=
                   ((pair_w == `PAIR_APP) ? `LC_APP : `LC_FILE)) begin
        chk_sw = `SW_BAD_LEN;
      end else if (pair_w == `PAIR_APP && (cnt_r != `LEN_SEL_APP ||
                   frm_r[12] != `LE_APP)) begin
        chk_sw = `SW_BAD_LEN;
      end else if (pair_w != `PAIR_APP && cnt_r != `LEN_SEL_FILE) begin
        chk_sw = `SW_BAD_LEN;
      end else if (pair_w == `PAIR_APP) begin
        if ({frm_r[5], frm_r[6], frm_r[7], frm_r[8], frm_r[9], frm_r[10],
             frm_r[11]} != `AID_NDEF) begin
          chk_sw = `SW_BAD_DATA;
        end else begin
          chk_tgt = SEL_APP;
        end
      end else if (pair_w == `PAIR_FILE) begin
        // other identifiers reach here and are refused with SW_BAD_DATA
        if (id_w == `FID_CC) begin
          chk_tgt = SEL_CC;
        end else if (id_w == `FID_NDEF) begin
          chk_tgt = SEL_NDEF;
        end else begin
          chk_sw = `SW_BAD_DATA;
        end
      end else begin
        chk_tgt = SEL_EF;
      end
    end else if (frm_r[1] == `INS_READ) begin
      if (cnt_r != `LEN_READ) begin
        chk_sw = `SW_BAD_LEN;
      end else if (frm_r[4] < `LE_MIN || frm_r[4] > `LE_MAX) begin
        chk_sw = `SW_BAD_LEN;
      end else begin
        chk_rd = 1'b1;
      end
    end else begin
      chk_sw = `SW_BAD_INS;
    end
  end

  // command sequencer
  always_comb begin
    state_nxt = state_r;
    frm_nxt = frm_r;
    cnt_nxt = cnt_r;
    sw_nxt = sw_r;
    sel_nxt = sel_r;
    fid_nxt = fid_r;
    addr_nxt = addr_r;
    left_nxt = left_r;
    data_nxt = data_r;
    push_if.valid = 1'b0;
    push_if.data = {1'b0, data_r};
    unique case (state_r)
      S_RX: if (take) begin
        if (cnt_r < 5'(`FRAME_MAX)) begin
          frm_nxt[cnt_r[3:0]] = i_rx_data;
        end
        cnt_nxt = (cnt_r == `LEN_SAT) ? cnt_r : cnt_r + 5'h1;
        if (i_rx_last) begin
          state_nxt = S_CHK;
        end
      end
      S_CHK: begin
        sw_nxt = chk_sw;
        if (chk_sw == `SW_OK && frm_r[1] == `INS_SELECT) begin
          sel_nxt = chk_tgt;
          fid_nxt = id_w;
        end
        if (chk_rd) begin
          addr_nxt = pair_w;
          left_nxt = frm_r[4];
          state_nxt = S_MRD;
        end else begin
          state_nxt = S_SW1;
        end
      end
      S_MRD: state_nxt = S_MWT;
      S_MWT: begin
        data_nxt = i_mem_rdata;
        state_nxt = S_DATA;
      end
      S_DATA: begin
        push_if.valid = 1'b1;
        if (push_if.ready) begin
          addr_nxt = addr_r + 16'h1;
          left_nxt = left_r - 8'h1;
          state_nxt = (left_r == 8'h1) ? S_SW1 : S_MRD;
        end
      end
      S_SW1: begin
        push_if.valid = 1'b1;
        push_if.data = {1'b0, sw_r[15:8]};
        if (push_if.ready) begin
          state_nxt = S_SW2;
        end
      end
      S_SW2: begin
        push_if.valid = 1'b1;
        push_if.data = {1'b1, sw_r[7:0]};
        if (push_if.ready) begin
          cnt_nxt = 5'h0;
          state_nxt = S_RX;
        end
      end
    endcase
    rx_rdy_nxt = (state_nxt == S_RX);
    rd_nxt = (state_nxt == S_MRD);
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state_r <= S_RX;
      frm_r <= '{default: 8'h00};
      cnt_r <= 5'h0;
      sw_r <= `SW_OK;
      sel_r <= SEL_NONE;
      fid_r <= 16'h0000;
      addr_r <= 16'h0000;
      left_r <= 8'h00;
      data_r <= 8'h00;
      rx_rdy_r <= 1'b0;
      rd_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      frm_r <= frm_nxt;
      cnt_r <= cnt_nxt;
      sw_r <= sw_nxt;
      sel_r <= sel_nxt;
      fid_r <= fid_nxt;
      addr_r <= addr_nxt;
      left_r <= left_nxt;
      data_r <= data_nxt;
      rx_rdy_r <= rx_rdy_nxt;
      rd_r <= rd_nxt;
    end
  end

  resp_buffer u_buf (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .in_if(push_if),
    .out_if(tx_if)
  );

  assign tx_if.ready = i_tx_ready;
  assign o_tx_valid = tx_if.valid;
  assign o_tx_data = tx_if.data[7:0];
  assign o_tx_last = tx_if.data[8];
  assign o_rx_ready = rx_rdy_r;
  assign o_mem_rd = rd_r;
  assign o_mem_addr = addr_r;
  assign o_sel_target = sel_r;
  assign o_sel_fid = fid_r;

  // checking helpers
  logic [7:0] dcnt_r, le_r;
  logic rdop_r;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      dcnt_r <= 8'h00;
      le_r <= 8'h00;
      rdop_r <= 1'b0;
    end else if (state_r == S_CHK) begin
      dcnt_r <= 8'h00;
      le_r <= frm_r[4];
      rdop_r <= chk_rd;
    end else if (state_r == S_DATA && push_if.ready) begin
      dcnt_r <= dcnt_r + 8'h1;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  sequence s_chk_err;
    state_r == S_CHK && chk_sw != `SW_OK;
  endsequence
  sequence s_status_only;
    state_r == S_SW1 && !o_mem_rd;
  endsequence

  property p_cla_err;
    state_r == S_CHK && frm_r[0] != `CLA_OK |=>
      sw_r == `SW_BAD_CLA && state_r == S_SW1 && sel_r == $past(sel_r);
  endproperty
  a_cla_err: assert property (p_cla_err)
    else $error("nonzero class not rejected");

  property p_pair_err;
    state_r == S_CHK && frm_r[0] == `CLA_OK && frm_r[1] == `INS_SELECT &&
      cnt_r > 5'h3 && pair_w != `PAIR_EF && pair_w != `PAIR_APP &&
      pair_w != `PAIR_FILE |=> sw_r == `SW_BAD_P1P2;
  endproperty
  a_pair_err: assert property (p_pair_err)
    else $error("bad parameter pair not rejected");

  property p_lc_err;
    state_r == S_CHK && frm_r[0] == `CLA_OK && frm_r[1] == `INS_SELECT &&
      cnt_r > 5'h4 && (pair_w == `PAIR_EF || pair_w == `PAIR_APP ||
      pair_w == `PAIR_FILE) && frm_r[4] !=
      ((pair_w == `PAIR_APP) ? `LC_APP : `LC_FILE) |=> sw_r == `SW_BAD_LEN;
  endproperty
  a_lc_err: assert property (p_lc_err)
    else $error("select accepted with wrong data length");

  property p_app_le;
    state_r == S_CHK && chk_tgt == SEL_APP && chk_sw == `SW_OK |->
      cnt_r == `LEN_SEL_APP && frm_r[12] == `LE_APP;
  endproperty
  a_app_le: assert property (p_app_le)
    else $error("application select accepted with bad expected length");

  property p_file_id;
    state_r == S_CHK && chk_sw == `SW_OK && pair_w == `PAIR_FILE &&
      frm_r[1] == `INS_SELECT |=>
      (sel_r == SEL_CC && o_sel_fid == `FID_CC) ||
      (sel_r == SEL_NDEF && o_sel_fid == `FID_NDEF);
  endproperty
  a_file_id: assert property (p_file_id)
    else $error("file select chose wrong target");

  property p_ef_any;
    state_r == S_CHK && frm_r[0] == `CLA_OK && frm_r[1] == `INS_SELECT &&
      pair_w == `PAIR_EF && cnt_r == `LEN_SEL_FILE &&
      frm_r[4] == `LC_FILE |=> sw_r == `SW_OK && sel_r == SEL_EF;
  endproperty
  a_ef_any: assert property (p_ef_any)
    else $error("elementary file select refused");

  property p_read_len;
    state_r == S_CHK && frm_r[0] == `CLA_OK && frm_r[1] == `INS_READ &&
      cnt_r != `LEN_READ |=> sw_r == `SW_BAD_LEN;
  endproperty
  a_read_len: assert property (p_read_len)
    else $error("read with wrong frame length accepted");

  property p_read_addr;
    state_r == S_CHK && chk_rd |=> o_mem_rd && o_mem_addr == $past(pair_w);
  endproperty
  a_read_addr: assert property (p_read_addr)
    else $error("read start address wrong");

  property p_read_count;
    $rose(state_r == S_SW1) && rdop_r |-> dcnt_r == le_r;
  endproperty
  a_read_count: assert property (p_read_count)
    else $error("read returned wrong byte count");

  property p_err_no_data;
    s_chk_err |=> s_status_only;
  endproperty
  a_err_no_data: assert property (p_err_no_data)
    else $error("error answer not status only");

  property p_sel_hold;
    state_r != S_CHK |=> $stable(sel_r);
  endproperty
  a_sel_hold: assert property (p_sel_hold)
    else $error("selected target changed without select");
endmodule // apdu_select_read_decoder

//--- dv/reader_model.sv
// reader side of the response stream: takes bytes with random stalls
// assumes the bench seeds $urandom and shares i_clk_sys
`timescale 1ns/1ps
module reader_model (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  output logic o_tx_ready
);
  // stalls about one cycle in four, never takes during reset
  always @(posedge i_clk_sys) begin
    #1;
    o_tx_ready <= !i_rst && ($urandom % 4 != 0);
  end
endmodule // reader_model

//--- dv/apdu_select_read_decoder_bench.sv
// self-checking bench of the select/read command decoder
// assumes apdu_pkg compiled first and apdu_consts.svh on the include path
`timescale 1ns/1ps
`include "apdu_consts.svh"
module apdu_select_read_decoder_bench;
  import apdu_pkg::*;
  typedef logic [7:0] byte_type;
  logic i_clk_sys, i_rst, i_rx_valid, i_rx_last, i_tx_ready;
  logic [7:0] i_rx_data, i_mem_rdata;
  logic o_rx_ready, o_tx_valid, o_tx_last, o_mem_rd, rd_seen;
  logic [7:0] o_tx_data, n;
  logic [15:0] o_mem_addr, o_sel_fid, ad_seen, a;
  sel_type o_sel_target;
  logic [8:0] exp_q[$];
  int fail_count = 0;
  int total_checks = 0;

  apdu_select_read_decoder dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_rx_valid(i_rx_valid), .i_rx_data(i_rx_data),
    .i_rx_last(i_rx_last), .o_rx_ready(o_rx_ready),
    .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data),
    .o_tx_last(o_tx_last), .i_tx_ready(i_tx_ready),
    .o_mem_rd(o_mem_rd), .o_mem_addr(o_mem_addr),
    .i_mem_rdata(i_mem_rdata), .o_sel_target(o_sel_target),
    .o_sel_fid(o_sel_fid));
  reader_model partner (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .o_tx_ready(i_tx_ready));

  initial begin
    i_clk_sys = 1'b0;
    forever #2 i_clk_sys = ~i_clk_sys;
  end

  function automatic logic [7:0] mem_val(input logic [15:0] ad);
    return ad[7:0] ^ {ad[11:8], ad[15:12]} ^ 8'h5A;
  endfunction

  // memory data valid the cycle after a strobe, toggling otherwise
  always @(posedge i_clk_sys) begin
    #1;
    if (i_rst) begin
      i_mem_rdata <= 8'h00;
      rd_seen <= 1'b0;
      ad_seen <= 16'h0000;
    end else begin
      i_mem_rdata <= rd_seen ? mem_val(ad_seen) : ~i_mem_rdata;
      rd_seen <= o_mem_rd;
      ad_seen <= o_mem_addr;
    end
  end

  task automatic chk(input string what, input logic [15:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // response monitor: oldest note against each byte taken
  always @(posedge i_clk_sys) begin
    if (!i_rst && o_tx_valid === 1'b1 && i_tx_ready) begin
      if (exp_q.size() == 0) begin
        chk("unexpected byte", {7'h00, o_tx_last, o_tx_data},
            16'hFFFF);
      end else begin
        chk("response", {7'h00, o_tx_last, o_tx_data},
            {7'h00, exp_q.pop_front()});
      end
    end
  end

  task automatic cmd(input byte_type f[$], input logic [15:0] sw,
                     input sel_type tgt);
    int i;
    int j;
    exp_q.push_back({1'b0, sw[15:8]});
    exp_q.push_back({1'b1, sw[7:0]});
    for (i = 0; i < f.size(); i++) begin
      i_rx_valid = 1'b1;
      i_rx_data = f[i];
      i_rx_last = (i == f.size() - 1);
      j = 0;
      do begin
        @(negedge i_clk_sys);
        j++;
      end while (o_rx_ready !== 1'b1 && j < 100);
      chk("rx ready", {15'h0000, o_rx_ready}, 16'h0001);
      @(posedge i_clk_sys);
      #1;
    end
    i_rx_valid = 1'b0;
    i_rx_last = 1'b0;
    i_rx_data = ~i_rx_data;
    for (i = 0; i < 2000 && (exp_q.size() != 0 || o_rx_ready !== 1'b1);
         i++) begin
      @(posedge i_clk_sys);
    end
    #1;
    chk("response wait", 16'(exp_q.size()), 16'h0000);
    chk("target", {13'h0000, o_sel_target}, {13'h0000, tgt});
  endtask

  task automatic rd(input logic [15:0] ad, input logic [7:0] le,
                    input sel_type tgt);
    int k;
    for (k = 0; k < le; k++) begin
      exp_q.push_back({1'b0, mem_val(ad + 16'(k))});
    end
    cmd('{8'h00, 8'hB0, ad[15:8], ad[7:0], le}, `SW_OK, tgt);
  endtask

  task automatic summarize();
    chk("pending bytes", 16'(exp_q.size()), 16'h0000);
    if (fail_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // watchdog: run needs well under 10000 cycles
  initial begin
    #(4 * 60000);
    fail_count++;
    summarize();
  end

  initial begin
    void'($urandom(32'hDEED));
    i_rst = 1'b1;
    i_rx_valid = 1'b0;
    i_rx_last = 1'b0;
    i_rx_data = 8'h00;
    repeat (16) @(posedge i_clk_sys);
    #1;
    i_rst = 1'b0;
    repeat (2) @(posedge i_clk_sys);
    #1;
    chk("reset target", {13'h0000, o_sel_target}, 16'h0000);
    cmd('{8'h01, 8'hA4, 8'h02, 8'h0C, 8'h02, 8'h11, 8'h22},
        `SW_BAD_CLA, SEL_NONE);
    cmd('{8'h01, 8'hB0, 8'h00, 8'h00, 8'h04}, `SW_BAD_CLA, SEL_NONE);
    cmd('{8'h00, 8'hA4, 8'h00, 8'h0C, 8'h02, 8'hE1, 8'h03},
        `SW_OK, SEL_CC);
    cmd('{8'h00, 8'hA4, 8'h04, 8'h00, 8'h07, 8'hD2, 8'h76, 8'h00,
          8'h00, 8'h85, 8'h01, 8'h01, 8'h00}, `SW_OK, SEL_APP);
    chk("app id", o_sel_fid, 16'hD276);
    cmd('{8'h00, 8'hA4, 8'h04, 8'h0C, 8'h07, 8'hD2, 8'h76, 8'h00,
          8'h00, 8'h85, 8'h01, 8'h01, 8'h00}, `SW_BAD_P1P2, SEL_APP);
    cmd('{8'h00, 8'hA4, 8'h04, 8'h00, 8'h02, 8'hD2, 8'h76},
        `SW_BAD_LEN, SEL_APP);
    cmd('{8'h00, 8'hA4, 8'h04, 8'h00, 8'h07, 8'hD2, 8'h76, 8'h00,
          8'h00, 8'h85, 8'h01, 8'h01, 8'h01}, `SW_BAD_LEN, SEL_APP);
    cmd('{8'h00, 8'hA4, 8'h04, 8'h00, 8'h07, 8'hD2, 8'h76, 8'h00,
          8'h00, 8'h85, 8'h01, 8'h02, 8'h00}, `SW_BAD_DATA, SEL_APP);
    cmd('{8'h00, 8'hA4, 8'h00, 8'h0C, 8'h02, 8'h01, 8'h03},
        `SW_OK, SEL_NDEF);
    cmd('{8'h00, 8'hA4, 8'h00, 8'h0C, 8'h02, 8'h12, 8'h34},
        `SW_BAD_DATA, SEL_NDEF);
    cmd('{8'h00, 8'hA4, 8'h02, 8'h0C, 8'h02, 8'h12, 8'h34, 8'h00},
        `SW_BAD_LEN, SEL_NDEF);
    cmd('{8'h00, 8'hA4, 8'h02, 8'h0C, 8'h03, 8'h12, 8'h34},
        `SW_BAD_LEN, SEL_NDEF);
    cmd('{8'h00}, `SW_BAD_LEN, SEL_NDEF);
    cmd('{8'h00, 8'hA4, 8'h02}, `SW_BAD_LEN, SEL_NDEF);
    cmd('{8'h00, 8'hA5, 8'h02, 8'h0C}, `SW_BAD_INS, SEL_NDEF);
    cmd('{8'h01, 8'hA5, 8'h02, 8'h0C}, `SW_BAD_CLA, SEL_NDEF);
    cmd('{8'h00, 8'hA4, 8'h01, 8'h0C, 8'h03, 8'h12, 8'h34},
        `SW_BAD_P1P2, SEL_NDEF);
    cmd('{8'h00, 8'hB0, 8'h00, 8'h10, 8'h02, 8'hAA},
        `SW_BAD_LEN, SEL_NDEF);
    cmd('{8'h00, 8'hB0, 8'h00, 8'h10, 8'h00}, `SW_BAD_LEN, SEL_NDEF);
    cmd('{8'h00, 8'hB0, 8'h00, 8'h10, 8'hFC}, `SW_BAD_LEN, SEL_NDEF);
    rd(16'h0180, 8'hFB, SEL_NDEF);
    rd(16'h0000, 8'h30, SEL_NDEF);
    repeat (12) begin
      a = 16'($urandom);
      cmd('{8'h00, 8'hA4, 8'h02, 8'h0C, 8'h02, a[15:8], a[7:0]},
          `SW_OK, SEL_EF);
      chk("file id", o_sel_fid, a);
      n = 8'($urandom_range(16, 1));
      rd(16'($urandom), n, SEL_EF);
    end
    summarize();
  end
endmodule // apdu_select_read_decoder_bench
